//--- src/ctm_pkg.sv
// Purpose: shared constants and types for the comm timeout monitor and modem reset
// Assumes: 50 MHz clock, classic Wishbone register access
// Notes: offsets are byte addresses of 32-bit words
package ctm_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned SEC_CYCLES = CLK_HZ;
    localparam int unsigned SEC_MIN = 1;
    localparam int unsigned SEC_MAX = 100;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_IRQ = 4'h8;
    localparam logic [3:0] ADDR_MASK = 4'hC;
    localparam int unsigned CTRL_CHAN_LSB = 0;
    localparam int unsigned CTRL_TYPE_LSB = 2;
    localparam int unsigned CTRL_TMO_LSB = 8;
    localparam int unsigned CTRL_RST_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0005_0532;
    localparam int unsigned IRQ_TIMEOUT = 0;
    localparam int unsigned IRQ_DONE = 1;
    typedef enum logic [1:0] {
        CTM_CH_PROG = 2'h0,
        CTM_CH_RS485 = 2'h1,
        CTM_CH_NET = 2'h2
    } ctm_chan_t;
    typedef enum logic [1:0] {
        CTM_MON_TX = 2'h0,
        CTM_MON_RX = 2'h1,
        CTM_MON_BOTH = 2'h2
    } ctm_mon_t;
    typedef struct packed {
        logic [2:0] tx;
        logic [2:0] rx;
    } ctm_act_t;
endpackage

//--- src/ctm_sec_tick.sv
// Purpose: one-cycle pulse once per second
// Assumes: clk_i at CLK_HZ
// Notes: restarts when clear_i is high
`timescale 1ns/100ps
`default_nettype none
module ctm_sec_tick
    import ctm_pkg::*;
#(
    parameter int unsigned CYCLES = SEC_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clear_i,
    output logic tick_o
);
    initial begin
        if (CYCLES < 2) begin
            $error("CYCLES must be at least 2");
        end
    end
    logic [31:0] cnt_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i || cnt_reg == 32'(CYCLES - 1)) begin
            cnt_reg <= 32'h0;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        tick_o <= !rst_i && !clear_i && cnt_reg == 32'(CYCLES - 1);
    end
endmodule
`default_nettype wire

//--- src/ctm_sec_count.sv
// Purpose: counts seconds up to a limit and flags arrival
// Assumes: tick_i is a one-cycle pulse
// Notes: saturates at the limit
`timescale 1ns/100ps
`default_nettype none
module ctm_sec_count (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic [6:0] limit_i,
    output logic reached_o
);
    logic [6:0] sec_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            sec_reg <= 7'h0;
        end else if (tick_i && sec_reg < limit_i) begin
            sec_reg <= sec_reg + 7'h1;
        end
    end
    assign reached_o = (sec_reg >= limit_i) && !clear_i;
endmodule
`default_nettype wire

//--- src/ctm_top.sv
// Purpose: comm inactivity monitor and embedded modem reset pulser
// Assumes: synchronous inputs, single clock, classic Wishbone slave
// Notes: seconds derive from a divider per function
//
// Behaviour
// - A reset request makes the block drive the modem reset active.
// - The modem stays in reset for the set period of 1 to 100 s, then is released.
// - A one-cycle done pulse is given in the cycle the modem is released.
// - The monitor runs while enable is high and stops on its falling edge.
// - The channel setting picks the one port that the monitor watches.
// - The inactivity timeout is set in whole seconds from 1 to 100.
// - The monitor type counts transmit, receive, or both directions of traffic.
// - While enabled, the timeout output rises once the timeout passes with no traffic.
// - The timeout output clears whenever enable changes state.
// - Per-direction activity status toggles while traffic occurs on the watched port.
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ctm_top
    import ctm_pkg::*;
#(
    parameter int unsigned SEC_CYC = SEC_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Port activity strobes
    input wire ctm_act_t act_i,
    // Monitor
    input wire logic mon_en_i,
    output logic timeout_o,
    output logic tx_flash_o,
    output logic rx_flash_o,
    // Modem reset
    input wire logic rst_req_i,
    output logic modem_rst_o,
    output logic rst_done_o,
    // Interrupt
    output logic irq_o
);
    initial begin
        if (SEC_CYC < 2) begin
            $error("SEC_CYC must be at least 2");
        end
    end

    function automatic logic [6:0] clamp_sec(input logic [7:0] v);
        if (v < 8'(SEC_MIN)) begin
            clamp_sec = 7'(SEC_MIN);
        end else if (v > 8'(SEC_MAX)) begin
            clamp_sec = 7'(SEC_MAX);
        end else begin
            clamp_sec = v[6:0];
        end
    endfunction

    logic [31:0] ctrl_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic [1:0] chan;
    logic [1:0] mtype;
    logic [6:0] tmo_sec;
    logic [6:0] rst_sec;
    logic bus_req;
    logic bus_wr;
    logic bus_rd;

    assign chan = ctrl_reg[CTRL_CHAN_LSB +: 2];
    assign mtype = ctrl_reg[CTRL_TYPE_LSB +: 2];
    assign tmo_sec = clamp_sec(ctrl_reg[CTRL_TMO_LSB +: 8]);
    assign rst_sec = clamp_sec(ctrl_reg[CTRL_RST_LSB +: 8]);
    assign bus_req = cyc_i && stb_i && !ack_o;
    assign bus_wr = bus_req && we_i;
    assign bus_rd = bus_req && !we_i;

    // Bus: answers one cycle after the request, any address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RESET;
            irq_mask_reg <= 2'h0;
        end else if (bus_wr) begin
            if (adr_i == ADDR_CTRL) begin
                for (int b = 0; b < 4; b++) begin
                    if (sel_i[b]) begin
                        ctrl_reg[8*b +: 8] <= dat_i[8*b +: 8];
                    end
                end
            end else if (adr_i == ADDR_MASK && sel_i[0]) begin
                irq_mask_reg <= dat_i[1:0];
            end
        end
    end

    // Monitor traffic selection
    logic tx_hit;
    logic rx_hit;
    logic traffic;
    always_comb begin
        tx_hit = 1'b0;
        rx_hit = 1'b0;
        case (chan)
            CTM_CH_PROG: begin
                tx_hit = act_i.tx[0];
                rx_hit = act_i.rx[0];
            end
            CTM_CH_RS485: begin
                tx_hit = act_i.tx[1];
                rx_hit = act_i.rx[1];
            end
            CTM_CH_NET: begin
                tx_hit = act_i.tx[2];
                rx_hit = act_i.rx[2];
            end
            default: begin
                tx_hit = 1'b0;
                rx_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (mtype)
            CTM_MON_TX: traffic = tx_hit;
            CTM_MON_RX: traffic = rx_hit;
            CTM_MON_BOTH: traffic = tx_hit || rx_hit;
            default: traffic = tx_hit || rx_hit;
        endcase
    end

    // Monitor timer
    logic en_d_reg;
    logic en_edge;
    logic mon_clear;
    logic mon_tick;
    logic mon_reached;
    assign en_edge = en_d_reg != mon_en_i;
    assign mon_clear = !mon_en_i || traffic || en_edge;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_d_reg <= 1'b0;
        end else begin
            en_d_reg <= mon_en_i;
        end
    end

    ctm_sec_tick #(
        .CYCLES(SEC_CYC)
    ) u_mon_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(mon_clear),
        .tick_o(mon_tick)
    );

    ctm_sec_count u_mon_count (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(mon_clear),
        .tick_i(mon_tick),
        .limit_i(tmo_sec),
        .reached_o(mon_reached)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i || en_edge) begin
            timeout_o <= 1'b0;
        end else if (mon_en_i && mon_reached) begin
            timeout_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_flash_o <= 1'b0;
            rx_flash_o <= 1'b0;
        end else begin
            tx_flash_o <= tx_flash_o ^ tx_hit;
            rx_flash_o <= rx_flash_o ^ rx_hit;
        end
    end

    // Modem reset sequencer
    typedef enum logic [1:0] {
        CTM_RS_IDLE = 2'b01,
        CTM_RS_HOLD = 2'b10
    } ctm_rs_t;
    ctm_rs_t rs_reg;
    logic rs_tick;
    logic rs_reached;
    logic rs_idle;
    assign rs_idle = rs_reg == CTM_RS_IDLE;

    ctm_sec_tick #(
        .CYCLES(SEC_CYC)
    ) u_rs_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(rs_idle),
        .tick_o(rs_tick)
    );

    ctm_sec_count u_rs_count (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(rs_idle),
        .tick_i(rs_tick),
        .limit_i(rst_sec),
        .reached_o(rs_reached)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rs_reg <= CTM_RS_IDLE;
            modem_rst_o <= 1'b0;
            rst_done_o <= 1'b0;
        end else begin
            rst_done_o <= 1'b0;
            case (rs_reg)
                CTM_RS_IDLE: begin
                    if (rst_req_i) begin
                        rs_reg <= CTM_RS_HOLD;
                        modem_rst_o <= 1'b1;
                    end
                end
                CTM_RS_HOLD: begin
                    if (rs_reached) begin
                        rs_reg <= CTM_RS_IDLE;
                        modem_rst_o <= 1'b0;
                        rst_done_o <= 1'b1;
                    end
                end
                default: begin
                    rs_reg <= CTM_RS_IDLE;
                    modem_rst_o <= 1'b0;
                end
            endcase
        end
    end

    // Interrupt status: set wins over the clear-on-read
    logic [1:0] irq_set;
    logic stat_rd;
    logic irq_timeout_d_reg;
    assign irq_set = {rst_done_o, timeout_o && !irq_timeout_d_reg};
    assign stat_rd = bus_rd && adr_i == ADDR_IRQ;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_timeout_d_reg <= 1'b0;
            irq_stat_reg <= 2'h0;
            irq_o <= 1'b0;
        end else begin
            irq_timeout_d_reg <= timeout_o;
            irq_stat_reg <= (stat_rd ? 2'h0 : irq_stat_reg) | irq_set;
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (bus_rd) begin
            case (adr_i)
                ADDR_CTRL: dat_o <= ctrl_reg;
                ADDR_STAT: dat_o <= {26'h0, en_d_reg, rx_flash_o, tx_flash_o,
                    rst_done_o, modem_rst_o, timeout_o};
                ADDR_IRQ: dat_o <= {30'h0, irq_stat_reg};
                ADDR_MASK: dat_o <= {30'h0, irq_mask_reg};
                default: dat_o <= 32'h0;
            endcase
        end
    end

    // Checks
    a_req_starts_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        rs_idle && rst_req_i |=> modem_rst_o) else $error("reset not asserted");
    a_one_cycle_req: assert property (@(posedge clk_i) disable iff (rst_i)
        rs_idle && rst_req_i ##1 !rst_req_i |=> modem_rst_o) else $error("short req lost");
    a_hold_until_done: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(modem_rst_o) |-> $past(rs_reached)) else $error("early release");
    a_done_at_release: assert property (@(posedge clk_i) disable iff (rst_i)
        rst_done_o |-> $fell(modem_rst_o)) else $error("done pulse misplaced");
    a_done_single: assert property (@(posedge clk_i) disable iff (rst_i)
        rst_done_o |=> !rst_done_o) else $error("done pulse too long");
    a_edge_clears_out: assert property (@(posedge clk_i) disable iff (rst_i)
        en_edge |=> !timeout_o) else $error("timeout not cleared");
    a_disabled_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        !mon_en_i ##1 !mon_en_i |=> !timeout_o) else $error("flag while disabled");
    a_traffic_no_rise: assert property (@(posedge clk_i) disable iff (rst_i)
        traffic && !timeout_o |=> !timeout_o) else $error("flag despite traffic");
    a_flash_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_hit |=> tx_flash_o != $past(tx_flash_o)) else $error("tx flash stuck");
    a_flag_needs_en: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(timeout_o) |-> $past(mon_en_i)) else $error("flag without enable");

    // Sequencer holds and stays quiet until the period is over, and stays released while idle with no request
    a_hold_stays: assert property (@(posedge clk_i) disable iff (rst_i)
        !rs_idle && !rs_reached |=> modem_rst_o) else $error("modem released early");
    a_no_early_done: assert property (@(posedge clk_i) disable iff (rst_i)
        !rs_idle && !rs_reached |=> !rst_done_o) else $error("done before release");
    a_idle_released: assert property (@(posedge clk_i) disable iff (rst_i)
        rs_idle && !rst_req_i |=> !modem_rst_o) else $error("reset without request");
    // Monitor flag and activity status
    a_flag_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        timeout_o && !en_edge |=> timeout_o) else $error("flag dropped while quiet");
    a_rise_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(timeout_o) |-> !$past(traffic)) else $error("flag rose after traffic");
    a_rx_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_hit |=> rx_flash_o != $past(rx_flash_o)) else $error("rx flash stuck");
    a_tx_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_hit |=> $stable(tx_flash_o)) else $error("tx flash without traffic");
    a_rx_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !rx_hit |=> $stable(rx_flash_o)) else $error("rx flash without traffic");
    // Interrupt status, mask and bus answer
    a_done_sets_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        rst_done_o |=> irq_stat_reg[IRQ_DONE]) else $error("done event lost");
    a_rise_sets_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        timeout_o && !irq_timeout_d_reg |=> irq_stat_reg[IRQ_TIMEOUT]) else $error("timeout event lost");
    a_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        stat_rd && !irq_set[IRQ_DONE] |=> !irq_stat_reg[IRQ_DONE]) else $error("status not cleared");
    a_irq_high: assert property (@(posedge clk_i) disable iff (rst_i)
        |(irq_stat_reg & irq_mask_reg) |=> irq_o) else $error("irq missing");
    a_irq_low: assert property (@(posedge clk_i) disable iff (rst_i)
        !(|(irq_stat_reg & irq_mask_reg)) |=> !irq_o) else $error("irq without cause");
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack longer than one cycle");
endmodule
`default_nettype wire

//--- sim/ctm_port_model.sv
// Purpose: far side model of the watched ports and the modem
// Assumes: traffic strobes last one cycle
// Notes: strobes come only on command from the bench
`timescale 1ns/100ps
`default_nettype none
module ctm_port_model
    import ctm_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Block side
    input wire logic modem_rst_i,
    output var ctm_act_t act_o,
    output logic modem_up_o
);
    initial act_o = '0;
    // Modem runs only while its reset is released
    assign modem_up_o = !modem_rst_i;
    task automatic strobe(input logic tx, input logic [1:0] port);
        @(posedge clk_i);
        if (tx) begin
            act_o.tx[port] <= 1'h1;
        end else begin
            act_o.rx[port] <= 1'h1;
        end
        @(posedge clk_i);
        act_o <= '0;
    endtask
endmodule
`default_nettype wire

//--- sim/test_ctm_top.sv
// Purpose: self-checking bench for the monitor and modem reset block
// Assumes: SEC_CYC of 10 cycles stands for one second
// Notes: traffic comes from the port model
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module test_ctm_top
    import ctm_pkg::*;
;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic ack, timeout, txf, rxf, mrst, done, irq, up;
    logic mon_en = 1'h0;
    logic rst_req = 1'h0;
    ctm_act_t act;
    int fails = 0;
    int n_tests = 0;
    ctm_top #(.SEC_CYC(10)) ctm_top_inst (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o),
        .ack_o(ack), .act_i(act), .mon_en_i(mon_en), .timeout_o(timeout),
        .tx_flash_o(txf), .rx_flash_o(rxf), .rst_req_i(rst_req),
        .modem_rst_o(mrst), .rst_done_o(done), .irq_o(irq));
    ctm_port_model ctm_port_model_inst (.clk_i(clk), .modem_rst_i(mrst), .act_o(act),
        .modem_up_o(up));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic stop_test();
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 20);
        `CHK(ack, 1'h1)
        rd = dat_o;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk);
    endtask
    task automatic t_modem();
        int n;
        wb(1'h1, ADDR_MASK, 32'h3);
        wb(1'h1, ADDR_CTRL, 32'h0003_0102);
        rst_req <= 1'h1;
        @(posedge clk);
        rst_req <= 1'h0;
        @(posedge clk);
        `CHK(mrst, 1'h1)
        n = 1;
        // A second request while held must not stretch the period
        while (done !== 1'h1 && n < 200) begin
            rst_req <= (n == 8);
            @(posedge clk);
            n++;
        end
        `CHK(n >= 29 && n <= 33, 1'h1)
        `CHK(mrst, 1'h0)
        @(posedge clk);
        `CHK(done, 1'h0)
        `CHK(up, 1'h1)
        // Status bit lands one edge after done, irq one edge after that
        @(posedge clk);
        `CHK(irq, 1'h1)
        wb(1'h0, ADDR_IRQ, 32'h0);
        `CHK(rd, 32'h2)
        repeat (2) @(posedge clk);
        `CHK(irq, 1'h0)
    endtask
    task automatic t_mon(input logic [1:0] ch, input logic [1:0] ty);
        logic [1:0] oth;
        logic m;
        logic f;
        int n;
        oth = (ch == 2'h2) ? 2'h0 : ch + 2'h1;
        m = (ty != 2'h1);
        wb(1'h1, ADDR_CTRL, {8'h0, 8'h01, 8'h01, 4'h0, ty, ch});
        mon_en <= 1'h1;
        repeat (8) begin
            f = m ? txf : rxf;
            ctm_port_model_inst.strobe(m, ch);
            repeat (2) @(posedge clk);
            `CHK(timeout, 1'h0)
            if (ty == 2'h2) begin
                `CHK(m ? txf : rxf, !f)
                m = !m;
            end
        end
        // Only traffic that must be ignored from here on
        n = 0;
        while (timeout !== 1'h1 && n < 40) begin
            if (ty != 2'h2 && n[1]) begin
                ctm_port_model_inst.strobe(ty == 2'h1, ch);
            end else begin
                ctm_port_model_inst.strobe(n[1], oth);
            end
            n += 2;
        end
        `CHK(n >= 8 && n <= 14, 1'h1)
        mon_en <= 1'h0;
        repeat (3) @(posedge clk);
        `CHK(timeout, 1'h0)
        repeat (15) @(posedge clk);
        `CHK(timeout, 1'h0)
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        wb(1'h0, ADDR_CTRL, 32'h0);
        `CHK(rd, CTRL_RESET)
        wb(1'h0, 4'h2, 32'h0);
        `CHK(rd, 32'h0)
        t_modem();
        for (int c = 0; c < 3; c++) begin
            for (int t = 0; t < 3; t++) begin
                t_mon(2'(c), 2'(t));
            end
        end
        `CHK(irq, 1'h1)
        wb(1'h0, ADDR_IRQ, 32'h0);
        `CHK(rd, 32'h1)
        stop_test();
    end
endmodule
`default_nettype wire
